// >>> verilog/ldo_params.svh
`ifndef LDO_PARAMS_SVH
`define LDO_PARAMS_SVH
`define LDO_SFR_ADDR      8'hC9
`define LDO_SFR_PAGE      8'h00
`define LDO_BIT_DISABLE   7
`define LDO_BIT_RESERVED  6
`define LDO_BIT_LEVEL     4
`define LDO_BIT_DROPOUT   0
`define LDO_RST_DISABLE   1'h0
`define LDO_RST_RESERVED  1'h1
`define LDO_RST_LEVEL     1'h1
`define LDO_READ_MASK     8'hD1
`define LDO_SYNC_STAGES   2
`endif

// >>> verilog/ldo_pkg.sv
package ldo_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] page;
    logic [7:0] wdata;
  } ldo_sfr_req_t;

  typedef struct packed {
    logic irq_enable;
    logic irq_priority;
  } ldo_irq_cfg_t;

  typedef struct packed {
    logic       regulator_disable_bit;
    logic       output_level_select;
    logic [7:0] rdata;
    logic       rd_hit;
  } ldo_state_t;
endpackage

// >>> verilog/ldo_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ldo_sync (
  input  wire logic clk,     // system clock
  input  wire logic rst_b,   // async reset, active low
  input  wire logic d_in,    // asynchronous level
  output logic      q_out    // synchronised level
);
  logic [1:0] stage_reg;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_reg <= 2'h0;
    end else begin
      stage_reg <= {stage_reg[0], d_in};
    end
  end

  assign q_out = stage_reg[1];
endmodule
`default_nettype wire

// >>> verilog/ldo_regulator_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "ldo_params.svh"
module ldo_regulator_control (
  input  wire logic                  clk,                   // 40 MHz clock
  input  wire logic                  rst_b,                 // async, low
  input  wire ldo_pkg::ldo_sfr_req_t sfr_req,               // bus request
  output logic [7:0]                 sfr_rdata,             // read data
  output logic                       sfr_rd_hit,            // read answered
  input  wire ldo_pkg::ldo_irq_cfg_t irq_cfg,               // enable, prio
  input  wire logic                  dropout_raw,           // comparator
  output logic                       regulator_disable_bit, // 1 = off
  output logic                       output_level_select,   // 1 = 2.6 V
  output logic                       dropout_irq,           // live request
  output logic                       dropout_irq_priority   // 1 = high
);
  ldo_pkg::ldo_state_t state_reg;
  ldo_pkg::ldo_state_t state_next;
  logic                dropout_sync;
  logic                hit;
  logic                wr_hit;
  logic                rd_take;
  logic [7:0]          read_value;

  ldo_sync u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d_in  (dropout_raw),
    .q_out (dropout_sync)
  );

  assign hit = (sfr_req.addr == `LDO_SFR_ADDR)
             && (sfr_req.page == `LDO_SFR_PAGE);
  // strobes qualified by the decode, shared by logic and checks
  assign wr_hit  = sfr_req.wr && hit;
  assign rd_take = sfr_req.rd && hit;

  // indicator is the live synchronised level, so it clears by itself
  always_comb begin
    read_value = 8'h00;
    read_value[`LDO_BIT_DISABLE]  = state_reg.regulator_disable_bit;
    read_value[`LDO_BIT_RESERVED] = `LDO_RST_RESERVED;
    read_value[`LDO_BIT_LEVEL]    = state_reg.output_level_select;
    read_value[`LDO_BIT_DROPOUT]  = dropout_sync;
  end

  always_comb begin
    state_next        = state_reg;
    state_next.rd_hit = rd_take;
    if (rd_take) begin
      state_next.rdata = read_value;
    end
    // only bits 7 and 4 store; reserved/unused/indicator ignore writes
    if (wr_hit) begin
      state_next.regulator_disable_bit =
        sfr_req.wdata[`LDO_BIT_DISABLE];
      state_next.output_level_select =
        sfr_req.wdata[`LDO_BIT_LEVEL];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg.regulator_disable_bit <= `LDO_RST_DISABLE;
      state_reg.output_level_select   <= `LDO_RST_LEVEL;
      state_reg.rdata                 <= 8'h00;
      state_reg.rd_hit                <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign regulator_disable_bit = state_reg.regulator_disable_bit;
  assign output_level_select   = state_reg.output_level_select;
  assign sfr_rdata             = state_reg.rdata;
  assign sfr_rd_hit            = state_reg.rd_hit;
  // no pending flag: request follows the condition directly
  assign dropout_irq = dropout_sync && irq_cfg.irq_enable;
  assign dropout_irq_priority = irq_cfg.irq_priority;

  // register bus checks
  chk_reset_enabled: assert property (@(posedge clk)
    $rose(rst_b)
    |-> regulator_disable_bit == `LDO_RST_DISABLE
        && output_level_select == `LDO_RST_LEVEL)
    else $error("regulator not enabled at 2.6 V after reset");

  chk_disable_write: assert property (@(posedge clk)
    disable iff (!rst_b)
    wr_hit
    |=> regulator_disable_bit == $past(sfr_req.wdata[`LDO_BIT_DISABLE]))
    else $error("disable bit did not take written value");

  chk_level_write: assert property (@(posedge clk)
    disable iff (!rst_b)
    wr_hit
    |=> output_level_select == $past(sfr_req.wdata[`LDO_BIT_LEVEL]))
    else $error("level bit did not take written value");

  chk_no_write_hold: assert property (@(posedge clk)
    disable iff (!rst_b)
    !wr_hit
    |=> $stable(regulator_disable_bit) && $stable(output_level_select))
    else $error("control bits changed without a write");

  chk_miss_no_write: assert property (@(posedge clk)
    disable iff (!rst_b)
    sfr_req.wr && !hit
    |=> $stable(regulator_disable_bit) && $stable(output_level_select))
    else $error("write to other address changed register");

  chk_read_fixed: assert property (@(posedge clk)
    disable iff (!rst_b)
    rd_take
    |=> sfr_rdata[`LDO_BIT_RESERVED] == `LDO_RST_RESERVED && sfr_rd_hit)
    else $error("reserved bit read wrong");

  chk_read_unused: assert property (@(posedge clk)
    disable iff (!rst_b)
    rd_take
    |=> (sfr_rdata & ~`LDO_READ_MASK) == 8'h00)
    else $error("unused bits read nonzero");

  chk_read_disable: assert property (@(posedge clk)
    disable iff (!rst_b)
    rd_take
    |=> sfr_rdata[`LDO_BIT_DISABLE] == $past(regulator_disable_bit))
    else $error("disable bit read wrong");

  chk_read_level: assert property (@(posedge clk)
    disable iff (!rst_b)
    rd_take
    |=> sfr_rdata[`LDO_BIT_LEVEL] == $past(output_level_select))
    else $error("level bit read wrong");

  chk_read_drop: assert property (@(posedge clk)
    disable iff (!rst_b)
    rd_take
    |=> sfr_rdata[`LDO_BIT_DROPOUT] == $past(dropout_sync))
    else $error("dropout indicator read wrong");

  chk_rd_hit_pulse: assert property (@(posedge clk)
    disable iff (!rst_b)
    !rd_take
    |=> !sfr_rd_hit)
    else $error("read answered without a hitting read");

  chk_rd_miss: assert property (@(posedge clk)
    disable iff (!rst_b)
    sfr_req.rd && !hit
    |=> !sfr_rd_hit)
    else $error("read of other address answered");

  chk_rdata_hold: assert property (@(posedge clk)
    disable iff (!rst_b)
    !rd_take
    |=> $stable(sfr_rdata))
    else $error("read data changed without a hitting read");

  // dropout path checks
  chk_reset_quiet: assert property (@(posedge clk)
    $rose(rst_b)
    |-> !dropout_sync && !dropout_irq)
    else $error("dropout path not cleared by reset");

  chk_sync_lat: assert property (@(posedge clk)
    disable iff (!rst_b)
    dropout_raw [*3]
    |-> dropout_sync)
    else $error("dropout not seen after two stages");

  chk_sync_no_bypass: assert property (@(posedge clk)
    disable iff (!rst_b)
    $rose(dropout_raw)
    |=> !dropout_sync)
    else $error("dropout passed the synchroniser too early");

  chk_drop_rise: assert property (@(posedge clk)
    disable iff (!rst_b)
    $rose(dropout_sync)
    |-> $past(dropout_raw, 2))
    else $error("indicator rose without the condition");

  chk_drop_fall: assert property (@(posedge clk)
    disable iff (!rst_b)
    $fell(dropout_sync)
    |-> !$past(dropout_raw, 2))
    else $error("indicator fell while condition held");

  chk_drop_clear: assert property (@(posedge clk)
    disable iff (!rst_b)
    (!dropout_raw) [*3]
    |-> !dropout_sync)
    else $error("indicator not cleared after condition ended");

  chk_irq_live: assert property (@(posedge clk)
    disable iff (!rst_b)
    (!dropout_raw) [*3]
    |-> !dropout_irq)
    else $error("interrupt held after condition ended");

  chk_irq_gate: assert property (@(posedge clk)
    disable iff (!rst_b)
    (irq_cfg.irq_enable && dropout_raw) [*3]
    |-> dropout_irq)
    else $error("interrupt missing while enabled in dropout");
endmodule
`default_nettype wire

// >>> verification/test_ldo_regulator_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_ldo_regulator_control;
  logic                  clk;
  logic                  rst_b;
  logic                  drop;
  ldo_pkg::ldo_sfr_req_t sfr_req;
  ldo_pkg::ldo_irq_cfg_t irq_cfg;
  logic [7:0]            sfr_rdata;
  logic                  sfr_rd_hit;
  logic                  dis;
  logic                  lvl;
  logic                  irq;
  logic                  prio;
  int                    bad_count;
  int                    cmp_count;

  ldo_regulator_control dut (.clk(clk), .rst_b(rst_b), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_rd_hit(sfr_rd_hit), .irq_cfg(irq_cfg),
    .dropout_raw(drop), .regulator_disable_bit(dis),
    .output_level_select(lvl), .dropout_irq(irq),
    .dropout_irq_priority(prio));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // each access is followed by an idle cycle so strobes never double-drive
  task automatic wr(input logic [7:0] a, input logic [7:0] p,
                    input logic [7:0] d);
    sfr_req = '{1'b1, 1'b0, a, p, d};
    step();
    sfr_req = '0;
    step();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] p,
                    input logic [7:0] exp, input logic hit);
    sfr_req = '{1'b0, 1'b1, a, p, 8'h00};
    step();
    sfr_req = '0;
    check(sfr_rdata, exp);
    check({7'h00, sfr_rd_hit}, {7'h00, hit});
    step();
  endtask

  task automatic test_done();
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // run needs about 56 cycles; allow generous slack
  initial begin
    #20000;
    bad_count++;
    test_done();
  end

  initial begin
    rst_b = 1'b0;
    sfr_req = '0;
    irq_cfg = '0;
    drop = 1'b0;
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    check({6'h00, dis, lvl}, 8'h01);
    rd(8'hC9, 8'h00, 8'h50, 1'b1);
    wr(8'hC9, 8'h00, 8'hFF);
    check({6'h00, dis, lvl}, 8'h03);
    rd(8'hC9, 8'h00, 8'hD0, 1'b1);
    wr(8'hC9, 8'h00, 8'h40);
    rd(8'hC9, 8'h00, 8'h40, 1'b1);
    wr(8'hC8, 8'h00, 8'hD0);
    wr(8'hC9, 8'h01, 8'hD0);
    rd(8'hC9, 8'h01, 8'h40, 1'b0);
    rd(8'hC9, 8'h00, 8'h40, 1'b1);
    irq_cfg = '{1'b1, 1'b1};
    step();
    check({6'h00, irq, prio}, 8'h01);
    drop = 1'b1;
    step();
    check({6'h00, irq, prio}, 8'h01);
    repeat (2) step();
    check({6'h00, irq, prio}, 8'h03);
    irq_cfg = '{1'b0, 1'b1};
    step();
    check({6'h00, irq, prio}, 8'h01);
    rd(8'hC9, 8'h00, 8'h41, 1'b1);
    drop = 1'b0;
    rd(8'hC9, 8'h00, 8'h41, 1'b1);
    rd(8'hC9, 8'h00, 8'h40, 1'b1);
    irq_cfg = '{1'b1, 1'b0};
    step();
    check({6'h00, irq, prio}, 8'h00);
    wr(8'hC9, 8'h00, 8'hC0);
    check({6'h00, dis, lvl}, 8'h02);
    rst_b = 1'b0;
    step();
    rst_b = 1'b1;
    step();
    check({6'h00, dis, lvl}, 8'h01);
    check(sfr_rdata, 8'h00);
    rd(8'hC9, 8'h00, 8'h50, 1'b1);
    test_done();
  end
endmodule
`default_nettype wire
